/* logic/swsid_buf.v */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module swsid_buf #(
  parameter W = 8
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Fill side
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready_q,
  // Drain side
  output reg [W-1:0] out_data_q,
  output reg out_valid_q,
  input wire out_ready
);

  reg [W-1:0] tail_q;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  wire push;
  wire pop;

  assign push = in_valid & in_ready_q;
  assign pop = out_valid_q & out_ready;

  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Storage: head is the output word itself, so no mux after flops
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      cnt_q <= 2'h0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {W{1'b0}};
      tail_q <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != 2'h2);
      out_valid_q <= (cnt_d != 2'h0);
      if (pop && cnt_q == 2'h2) begin
        out_data_q <= tail_q;
      end else if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1))) begin
        out_data_q <= in_data;
      end
      if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2 && pop))) begin
        tail_q <= in_data;
      end
    end
  end

endmodule

/* logic/swsid_core.v */
// Bit-level slave logic of a single-wire, open-drain serial number
// device: reset and presence, write and read slots, two speeds.
// Assumes a 50 MHz clock, an external pull-up on the line and that
// command decoding and the ROM contents live in the user logic.
`include "swsid_map.vh"

module swsid_core #(
  parameter RST_STD_CYC = `SWSID_RST_STD_US * `SWSID_CLK_MHZ,
  parameter PDL_STD_CYC = `SWSID_PDL_STD_US * `SWSID_CLK_MHZ
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Shared line, open drain
  input wire line_i,
  output reg line_o_q,
  output reg line_oe_n_q,
  // Speed control from command logic
  input wire od_enter,
  output reg od_q,
  // Events
  output reg reset_seen_q,
  output reg rx_drop_q,
  // Received bytes
  output wire [`SWSID_BYTE_W-1:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  // Bytes to return in read slots
  input wire [`SWSID_BYTE_W-1:0] tx_data,
  input wire tx_valid,
  output reg tx_ready_q
);

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  // Products are integers; the counters keep only their low bits
  localparam integer RST_OD_N = `SWSID_RST_OD_US * `SWSID_CLK_MHZ;
  localparam integer PDH_STD_N = `SWSID_PDH_STD_US * `SWSID_CLK_MHZ;
  localparam integer PDH_OD_N = `SWSID_PDH_OD_US * `SWSID_CLK_MHZ;
  localparam integer PDL_OD_N = `SWSID_PDL_OD_US * `SWSID_CLK_MHZ;
  localparam integer WSAMP_STD_N = `SWSID_WSAMP_STD_US * `SWSID_CLK_MHZ;
  localparam integer WSAMP_OD_N = `SWSID_WSAMP_OD_US * `SWSID_CLK_MHZ;
  localparam integer RHOLD_STD_N = `SWSID_RHOLD_STD_US * `SWSID_CLK_MHZ;
  localparam integer RHOLD_OD_N = `SWSID_RHOLD_OD_US * `SWSID_CLK_MHZ;
  localparam [`SWSID_CNT_W-1:0] RST_STD = RST_STD_CYC[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] RST_OD = RST_OD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] PDH_STD = PDH_STD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] PDH_OD = PDH_OD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] PDL_STD = PDL_STD_CYC[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] PDL_OD = PDL_OD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] WSAMP_STD = WSAMP_STD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] WSAMP_OD = WSAMP_OD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] RHOLD_STD = RHOLD_STD_N[`SWSID_CNT_W-1:0];
  localparam [`SWSID_CNT_W-1:0] RHOLD_OD = RHOLD_OD_N[`SWSID_CNT_W-1:0];

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOW = 2'h1;
  localparam [1:0] ST_PDH = 2'h2;
  localparam [1:0] ST_PDL = 2'h3;

  // Speed-dependent count selection, used for every waveform
  function [`SWSID_CNT_W-1:0] pick;
    input od;
    input [`SWSID_CNT_W-1:0] std_cnt;
    input [`SWSID_CNT_W-1:0] od_cnt;
    begin
      pick = od ? od_cnt : std_cnt;
    end
  endfunction

  reg [2:0] sync_q;
  reg lvl_q;
  reg lvl_prev_q;
  reg [1:0] st_q;
  reg [`SWSID_CNT_W-1:0] cnt_q;
  reg [`SWSID_BYTE_W-1:0] rx_sh_q;
  reg [`SWSID_BIT_IDX_W-1:0] rx_idx_q;
  reg [`SWSID_BYTE_W-1:0] tx_sh_q;
  reg [`SWSID_BIT_IDX_W-1:0] tx_idx_q;
  reg tx_busy_q;
  reg [`SWSID_BYTE_W-1:0] push_data_q;
  reg push_q;
  wire buf_ready;
  wire fall;
  wire rise;

  // ----------------------------------------------------------------
  // Line input: three flops, a change counts when two agree
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      sync_q <= 3'h7;
      lvl_q <= 1'b1;
      lvl_prev_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], line_i};
      if (sync_q[1] == sync_q[2]) begin
        lvl_q <= sync_q[2];
      end
      lvl_prev_q <= lvl_q;
    end
  end

  // Slots only ever open on the master's falling edge
  assign fall = lvl_prev_q & ~lvl_q;
  assign rise = ~lvl_prev_q & lvl_q;

  // ----------------------------------------------------------------
  // Slot and reset sequencer
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      // Power-up presence: allowed before the master's first access
      st_q <= ST_PDH;
      cnt_q <= {`SWSID_CNT_W{1'b0}};
      od_q <= 1'b0;
      line_o_q <= 1'b0;
      line_oe_n_q <= 1'b1;
      reset_seen_q <= 1'b0;
      rx_drop_q <= 1'b0;
      rx_sh_q <= `SWSID_RST_BYTE;
      rx_idx_q <= {`SWSID_BIT_IDX_W{1'b0}};
      tx_sh_q <= `SWSID_RST_BYTE;
      tx_idx_q <= {`SWSID_BIT_IDX_W{1'b0}};
      tx_busy_q <= 1'b0;
      tx_ready_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= `SWSID_RST_BYTE;
    end else begin
      reset_seen_q <= 1'b0;
      rx_drop_q <= 1'b0;
      line_o_q <= 1'b0;
      if (push_q && buf_ready) begin
        push_q <= 1'b0;
      end
      if (tx_valid && tx_ready_q) begin
        tx_sh_q <= tx_data;
        tx_idx_q <= {`SWSID_BIT_IDX_W{1'b0}};
        tx_busy_q <= 1'b1;
        tx_ready_q <= 1'b0;
      end else begin
        tx_ready_q <= ~tx_busy_q & (st_q == ST_IDLE);
      end
      case (st_q)
        ST_IDLE: begin
          cnt_q <= {`SWSID_CNT_W{1'b0}};
          if (od_enter) begin
            od_q <= 1'b1;
          end
          if (fall) begin
            st_q <= ST_LOW;
            // A pending zero is driven from the slot start
            if (tx_busy_q && !tx_sh_q[0]) begin
              line_oe_n_q <= 1'b0;
            end
          end
        end
        ST_LOW: begin
          if (cnt_q != {`SWSID_CNT_W{1'b1}}) begin
            cnt_q <= cnt_q + 16'h0001;
          end
          if (!line_oe_n_q && cnt_q == pick(od_q, RHOLD_STD, RHOLD_OD)) begin
            line_oe_n_q <= 1'b1;
          end
          // Write bit taken once, past any write-one low time
          if (!tx_busy_q && cnt_q == pick(od_q, WSAMP_STD, WSAMP_OD)) begin
            rx_sh_q <= {lvl_q, rx_sh_q[`SWSID_BYTE_W-1:1]};
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == `SWSID_LAST_BIT) begin
              if (push_q && !buf_ready) begin
                rx_drop_q <= 1'b1;
              end else begin
                push_q <= 1'b1;
                push_data_q <= {lvl_q, rx_sh_q[`SWSID_BYTE_W-1:1]};
              end
            end
            // Master already let go: a write-one slot ends at the sample
            if (lvl_q) begin
              st_q <= ST_IDLE;
              cnt_q <= {`SWSID_CNT_W{1'b0}};
            end
          end
          // An early rise in a write slot waits for the sample point
          if (rise && line_oe_n_q &&
              (tx_busy_q || cnt_q > pick(od_q, WSAMP_STD, WSAMP_OD))) begin
            cnt_q <= {`SWSID_CNT_W{1'b0}};
            if (cnt_q >= pick(od_q, RST_STD, RST_OD)) begin
              // Reset: bit state dropped, speed kept or cleared
              st_q <= ST_PDH;
              reset_seen_q <= 1'b1;
              rx_idx_q <= {`SWSID_BIT_IDX_W{1'b0}};
              tx_busy_q <= 1'b0;
              if (cnt_q >= RST_STD) begin
                od_q <= 1'b0;
              end
            end else begin
              st_q <= ST_IDLE;
              if (tx_busy_q) begin
                tx_sh_q <= {1'b0, tx_sh_q[`SWSID_BYTE_W-1:1]};
                tx_idx_q <= tx_idx_q + 3'h1;
                if (tx_idx_q == `SWSID_LAST_BIT) begin
                  tx_busy_q <= 1'b0;
                end
              end
            end
          end
        end
        ST_PDH: begin
          cnt_q <= cnt_q + 16'h0001;
          if (fall) begin
            // Master cut the wait short; treat as a new low period
            st_q <= ST_LOW;
            cnt_q <= {`SWSID_CNT_W{1'b0}};
          end else if (cnt_q == pick(od_q, PDH_STD, PDH_OD)) begin
            st_q <= ST_PDL;
            cnt_q <= {`SWSID_CNT_W{1'b0}};
            line_oe_n_q <= 1'b0;
          end
        end
        ST_PDL: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == pick(od_q, PDL_STD, PDL_OD)) begin
            st_q <= ST_IDLE;
            line_oe_n_q <= 1'b1;
            cnt_q <= {`SWSID_CNT_W{1'b0}};
          end
        end
        default: begin
          st_q <= ST_IDLE;
          line_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Received bytes: a stalled reader costs no byte while room lasts
  // ----------------------------------------------------------------
  swsid_buf #(
    .W(`SWSID_BYTE_W)
  ) u_rx_buf (
    .clock(clock),
    .rst(rst),
    .in_data(push_data_q),
    .in_valid(push_q),
    .in_ready_q(buf_ready),
    .out_data_q(rx_data),
    .out_valid_q(rx_valid),
    .out_ready(rx_ready)
  );

endmodule

/* logic/swsid_map.vh */
// Constants of the single-wire serial number slave: clock rate,
// line timing in microseconds, counter and byte widths and reset values.
// Assumes a 50 MHz core clock; included by the design files.
`ifndef SWSID_MAP_VH
`define SWSID_MAP_VH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define SWSID_CLK_MHZ 50

// ----------------------------------------------------------------
// Reset classification, microseconds
// ----------------------------------------------------------------
`define SWSID_RST_STD_US 480
`define SWSID_RST_OD_US 60
`define SWSID_RST_OD_MAX_US 80

// ----------------------------------------------------------------
// Presence answer, microseconds
// ----------------------------------------------------------------
`define SWSID_PDH_STD_US 30
`define SWSID_PDH_OD_US 3
`define SWSID_PDL_STD_US 120
`define SWSID_PDL_OD_US 12

// ----------------------------------------------------------------
// Slot timing, microseconds
// ----------------------------------------------------------------
`define SWSID_WSAMP_STD_US 30
`define SWSID_WSAMP_OD_US 4
`define SWSID_RHOLD_STD_US 30
`define SWSID_RHOLD_OD_US 4

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SWSID_CNT_W 16
`define SWSID_BYTE_W 8
`define SWSID_BIT_IDX_W 3
`define SWSID_LAST_BIT 3'h7
`define SWSID_RST_BYTE 8'h00

`endif

/* test/swsid_master.sv */
// Bus master model: resets, write and read slots, whole bytes.
// Assumes a 50 MHz clock and a pull-up on the shared line.
module swsid_master (
  // Clock
  input logic clock,
  // Line
  input logic dev_oe_n,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic low_q = 1'b0;
  logic od = 1'b0;
  // Wired low, released high while idle or suspended
  assign line = (low_q || !dev_oe_n) ? 1'b0 : 1'b1;
  task automatic slot(input int lo, input int len, input int smp, output logic v);
    v = 1'b1;
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      low_q <= (i < lo);
      if (i == smp)
        v = line;
    end
  endtask
  task automatic bus_reset(input int len, output logic p);
    slot(len, len + (od ? 1000 : 5000), len + (od ? 400 : 3200), p);
  endtask
  task automatic xfer(input logic rd, input logic [7:0] wb, output logic [7:0] rb);
    logic v;
    for (int i = 0; i < 8; i++) begin
      if (od)
        slot((rd || wb[i]) ? 50 : 400, 450, 90, v);
      else
        slot((rd || wb[i]) ? 250 : 3000, 3250, 700, v);
      rb[i] = v;
    end
  endtask
endmodule

/* test/swsid_monitor.sv */
// Checker for the single-wire slave core, bound to its top ports.
// Assumes line_i is the wired level of master and device.
module swsid_monitor #(
  parameter int RST_STD_CYC = 24000,
  parameter int PDL_STD_CYC = 6000
) (
  // Clock and reset
  input logic clock,
  input logic rst,
  // Line
  input logic line_i,
  input logic line_o_q,
  input logic line_oe_n_q,
  // Speed and events
  input logic od_enter,
  input logic od_q,
  input logic reset_seen_q,
  input logic rx_drop_q,
  // Streams
  input logic [7:0] rx_data,
  input logic rx_valid,
  input logic rx_ready,
  input logic [7:0] tx_data,
  input logic tx_valid,
  input logic tx_ready_q
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_q = 0;
  int rise_q = 0;
  int drv_q = 0;
  logic ln_q = 1'b1;
  logic oe_q = 1'b1;
  logic arm_q = 1'b0;
  logic pres_q = 1'b0;
  // ----
  // Helper counters
  // ----
  always @(posedge clock) begin
    ln_q <= line_i;
    oe_q <= line_oe_n_q;
    run_q <= line_i ? run_q : (ln_q ? 1 : run_q + 1);
    rise_q <= (line_i && !ln_q) ? 0 : rise_q + 1;
    drv_q <= line_oe_n_q ? 0 : drv_q + 1;
    arm_q <= reset_seen_q ? 1'b1 : (line_oe_n_q ? arm_q : 1'b0);
    pres_q <= (oe_q && !line_oe_n_q) ? ln_q : pres_q;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_pres_start;
    $fell(line_oe_n_q) && $past(line_i) && arm_q;
  endsequence
  sequence s_drive_end;
    $rose(line_oe_n_q);
  endsequence
  a_open_drain: assert property (line_o_q == 1'b0)
    else $error("line driven high");
  a_reset_seen: assert property (reset_seen_q |->
    run_q >= (od_q ? 3000 : RST_STD_CYC) ##1 !reset_seen_q)
    else $error("reset flagged on short low");
  a_od_exit: assert property ($fell(od_q) |-> $past(rst) || run_q >= RST_STD_CYC)
    else $error("overdrive left without long reset");
  a_od_entry: assert property ($rose(od_q) |-> $past(od_enter))
    else $error("overdrive entered unasked");
  a_pres_delay: assert property (s_pres_start |-> (od_q ? rise_q inside {[145:165]}
    : rise_q inside {[1495:1515]})) else $error("presence delay wrong");
  a_pres_len: assert property (s_drive_end and pres_q |-> (od_q ? drv_q inside {[598:602]}
    : drv_q inside {[PDL_STD_CYC-2:PDL_STD_CYC+2]})) else $error("presence length wrong");
  a_read_len: assert property (s_drive_end and !pres_q |-> (od_q ? drv_q inside {[198:202]}
    : drv_q inside {[1498:1502]})) else $error("read drive length wrong");
  a_drive_cause: assert property ($fell(line_oe_n_q) && !$past(line_i) |-> !tx_ready_q)
    else $error("drive without loaded byte");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx word not held");
  a_tx_take: assert property (tx_valid && tx_ready_q |=> !tx_ready_q)
    else $error("tx ready stayed high");
  a_drop_full: assert property (rx_drop_q |-> rx_valid ##1 !rx_drop_q)
    else $error("drop while not full");
endmodule
bind swsid_core swsid_monitor #(.RST_STD_CYC(RST_STD_CYC), .PDL_STD_CYC(PDL_STD_CYC)) u_mon (
  .clock(clock), .rst(rst), .line_i(line_i), .line_o_q(line_o_q), .line_oe_n_q(line_oe_n_q),
  .od_enter(od_enter), .od_q(od_q), .reset_seen_q(reset_seen_q), .rx_drop_q(rx_drop_q),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready_q(tx_ready_q));

/* test/test_single_wire_serial_id_slave.sv */
// Self-checking bench for the single-wire slave core.
// Assumes the core under logic/, the master model and the checker.
module test_single_wire_serial_id_slave;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic od; logic rd; logic [7:0] b;} swsid_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic od_enter = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic line_i, line_o_q, line_oe_n_q, od_q, reset_seen_q, rx_drop_q, rx_valid, tx_ready_q;
  logic [7:0] rx_data;
  logic [7:0] rb;
  logic p;
  int bad_count = 0;
  int tests_run = 0;
  int seen_n = 0;
  int drop_n = 0;
  // Columns: overdrive, read, byte
  swsid_row_t rows [5] = '{10'h0A5, 10'h23C, 10'h396, 10'h380, 10'h27E};
  swsid_core #(.RST_STD_CYC(3500), .PDL_STD_CYC(3000)) DUT (
    .clock(clock), .rst(rst), .line_i(line_i), .line_o_q(line_o_q), .line_oe_n_q(line_oe_n_q),
    .od_enter(od_enter), .od_q(od_q), .reset_seen_q(reset_seen_q), .rx_drop_q(rx_drop_q),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready_q(tx_ready_q));
  swsid_master m (.clock(clock), .dev_oe_n(line_oe_n_q), .line(line_i));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    seen_n <= seen_n + (reset_seen_q === 1'b1);
    drop_n <= drop_n + (rx_drop_q === 1'b1);
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic pop(input logic [7:0] exp);
    check({rx_valid, rx_data}, {1'b1, exp});
    rx_ready <= 1'b1;
    @(posedge clock);
    rx_ready <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Short power-up wait: lands inside the unasked presence low
    repeat (1600) @(posedge clock);
    check(9'(line_oe_n_q), 9'h000);
    repeat (3000) @(posedge clock);
    // Power-up presence over before the master's first access
    check(9'(line_oe_n_q), 9'h001);
    m.bus_reset(3600, p);
    check({seen_n[0], 7'h00, p}, 9'h100);
    foreach (rows[i]) begin
      if (rows[i].od && od_q !== 1'b1) begin
        od_enter <= 1'b1;
        do @(posedge clock); while (od_q !== 1'b1);
        od_enter <= 1'b0;
        m.od = 1'b1;
        m.bus_reset(3200, p);
        check({od_q, 7'h00, p}, 9'h100);
      end
      if (rows[i].rd) begin
        tx_data <= rows[i].b;
        tx_valid <= 1'b1;
        do @(posedge clock); while (tx_ready_q !== 1'b1);
        tx_valid <= 1'b0;
        m.xfer(1'b1, 8'h00, rb);
        check({1'b0, rb}, {1'b0, rows[i].b});
      end else begin
        m.xfer(1'b0, rows[i].b, rb);
        pop(rows[i].b);
      end
    end
    // Receiver stalls: three words held, the fourth lost
    for (int k = 1; k < 5; k++)
      m.xfer(1'b0, 8'(k * 17), rb);
    check(9'(drop_n), 9'h001);
    pop(8'h11);
    pop(8'h22);
    pop(8'h33);
    check(9'(rx_valid), 9'h000);
    m.bus_reset(3200, p);
    check({od_q, 7'h00, p}, 9'h100);
    m.od = 1'b0;
    m.bus_reset(3600, p);
    check({od_q, 7'h00, p}, 9'h000);
    // Four master resets, no slot mistaken for one
    check(9'(seen_n), 9'h004);
    wrap_up();
  end
  // About 85000 cycles of traffic; margin on top
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
endmodule
